// ===== hw/dps_consts.svh
// constants of the debug protocol select watcher
// assumes nothing; included by the package and the design modules
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

// jtag-to-swd switch pattern, first bit received in bit 0
`define DPS_J2S_PAT 16'he79e
// swd-to-jtag switch pattern, first bit received in bit 0
`define DPS_S2J_PAT 16'he73c
// length of the compare window in line samples
`define DPS_WIN_LEN 16
// reset value of the compare window
`define DPS_WIN_RST 16'h0000
// reset value of the reset-condition history
`define DPS_HIST_RST 15'h0000

`endif

// ===== hw/dps_line_if.sv
// sample stream from the line sampler to the protocol selector
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`include "dps_consts.svh"

interface dps_line_if;
	logic strobe; // pulse: a new line sample was shifted in
	logic [`DPS_WIN_LEN-1:0] window; // last samples, oldest in bit 0

	modport src (output strobe, output window);
	modport dst (input strobe, input window);
endinterface

// ===== hw/dps_pkg.sv
// types shared by the debug protocol select watcher
// assumes dps_consts.svh is on the include path
`include "dps_consts.svh"

package dps_pkg;

	// protocol currently selected on the shared pins
	typedef enum logic [1:0] {
		DPS_JTAG,
		DPS_SWD,
		DPS_DORMANT
	} dps_mode_e;

	// state of the line sampler
	typedef struct packed {
		logic clk_meta; // first synchroniser stage, clock pin
		logic clk_sync; // second synchroniser stage, clock pin
		logic clk_prev; // last synced clock level
		logic dat_meta; // first synchroniser stage, mode/data pin
		logic dat_sync; // second synchroniser stage, mode/data pin
		logic strobe; // one cycle per debug clock rising edge
		logic [`DPS_WIN_LEN-1:0] window; // last 16 line samples
	} dps_smp_s;

	// state of the protocol selector
	typedef struct packed {
		dps_mode_e mode; // selected protocol
		logic armed; // pattern detection allowed
		logic alert_ok; // wake-up alert seen while dormant
		logic [`DPS_WIN_LEN-2:0] cond_hist; // reset condition per sample
		logic swd_reset_req; // one-cycle line-reset request
	} dps_sel_s;

endpackage

// ===== hw/dps_sampler.sv
// line sampler: synchronises the debug clock and mode/data pins,
// finds debug clock rising edges and keeps a 16-sample window
// assumes the debug clock is slow against the system clock
`timescale 1ns/1ps
`include "dps_consts.svh"

module dps_sampler
	import dps_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_debug_clock_pin,
	input wire logic i_debug_mode_data_pin,
	dps_line_if.src line
);

	dps_smp_s st; // registered state
	dps_smp_s next_st; // next state

	// next state: sync, edge find, shift
	always_comb begin
		next_st = st;
		next_st.clk_meta = i_debug_clock_pin;
		next_st.clk_sync = st.clk_meta;
		next_st.clk_prev = st.clk_sync;
		next_st.dat_meta = i_debug_mode_data_pin;
		next_st.dat_sync = st.dat_meta;
		next_st.strobe = st.clk_sync & ~st.clk_prev;
		// one sample per rising edge, newest enters at the top
		if (st.clk_sync && !st.clk_prev) begin
			next_st.window = {st.dat_sync, st.window[`DPS_WIN_LEN-1:1]};
		end
	end

	// state register
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, `DPS_WIN_RST};
		end else begin
			st <= next_st;
		end
	end

	assign line.strobe = st.strobe;
	assign line.window = st.window;

	// each strobe brings the synced line level of its edge into the window
	a_window_shift: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		st.strobe |-> st.window[`DPS_WIN_LEN-1] == $past(st.dat_sync))
		else $error("window did not take the sampled line level");

endmodule // dps_sampler

// ===== hw/dps_select.sv
// protocol select watcher of the dual protocol debug port
// assumes tap and two-wire logic report their reset states on
// i_sys_clk, and that wake-up alert and activation matchers
// deliver one-cycle pulses on i_sys_clk
//
// Summary of operation
// - jtag-to-swd needs tap reset at start
// - jtag-to-swd pattern 79e7 msb first
// - swd selection starts in line reset
// - pattern leaves the tap untouched
// - swd-to-jtag needs line reset at start
// - swd-to-jtag pattern 3ce7 msb first
// - dormant state is supported here
// - dormant ignores all but wake-up alert
// - activation code after alert picks protocol
// - dormant entry from jtag or swd
// - jtag activation keeps tap state
// - swd activation lands in line reset
// - two-wire-only port wakes up dormant
// - powerup reset selects jtag
// - after detection wait for reset condition
// - compare last 16 line samples
`timescale 1ns/1ps
`include "dps_consts.svh"

module dps_select
	import dps_pkg::*;
#(
	// set for a two-wire-only port: powerup then lands in dormant
	parameter bit SWD_ONLY = 1'b0
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_debug_clock_pin,
	input wire logic i_debug_mode_data_pin,
	input wire logic i_tap_in_tlr,
	input wire logic i_swd_line_reset,
	input wire logic i_enter_dormant,
	input wire logic i_alert_seen,
	input wire logic i_act_jtag,
	input wire logic i_act_swd,
	output logic o_jtag_sel,
	output logic o_swd_sel,
	output logic o_dormant,
	output logic o_swd_reset_req,
	output logic o_armed
);

	// powerup mode, fixed per build
	localparam dps_mode_e RST_MODE = SWD_ONLY ? DPS_DORMANT : DPS_JTAG;

	dps_line_if line (); // sample stream from the sampler
	dps_sel_s st; // registered state
	dps_sel_s next_st; // next state
	logic cond_now; // reset condition of selected protocol
	logic hit_j2s; // jtag-to-swd pattern accepted
	logic hit_s2j; // swd-to-jtag pattern accepted

	// pin synchronisers, edge finder and compare window
	dps_sampler u_sampler (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_debug_clock_pin(i_debug_clock_pin),
		.i_debug_mode_data_pin(i_debug_mode_data_pin),
		.line(line)
	);

	// reset condition: tap reset for jtag, line reset for two-wire
	always_comb begin
		unique case (st.mode)
			DPS_JTAG: begin
				cond_now = i_tap_in_tlr;
			end
			DPS_SWD: begin
				cond_now = i_swd_line_reset;
			end
			DPS_DORMANT: begin
				cond_now = 1'b0;
			end
			// unused mode code: no reset condition
			default: begin
				cond_now = 1'b0;
			end
		endcase
	end

	// pattern matches; cond_hist[0] is the condition seen at the
	// strobe of the first pattern bit, fifteen strobes back
	always_comb begin
		hit_j2s = line.strobe && st.armed && (st.mode == DPS_JTAG) &&
			(line.window == `DPS_J2S_PAT) && st.cond_hist[0];
		hit_s2j = line.strobe && st.armed && (st.mode == DPS_SWD) &&
			(line.window == `DPS_S2J_PAT) && st.cond_hist[0];
	end

	// next state of the selector
	always_comb begin
		next_st = st;
		next_st.swd_reset_req = 1'b0;
		// record the reset condition once per line sample
		if (line.strobe) begin
			next_st.cond_hist = {cond_now, st.cond_hist[`DPS_WIN_LEN-2:1]};
		end
		unique case (st.mode)
			DPS_JTAG: begin
				if (i_enter_dormant) begin
					// leave to dormant, tap keeps its state
					next_st.mode = DPS_DORMANT;
					next_st.alert_ok = 1'b0;
				end else if (hit_j2s) begin
					// selection moves and a line reset is requested; no reset to tap
					next_st.mode = DPS_SWD;
					next_st.armed = 1'b0;
					next_st.swd_reset_req = 1'b1;
				end else if (line.strobe && cond_now) begin
					next_st.armed = 1'b1;
				end
			end
			DPS_SWD: begin
				if (i_enter_dormant) begin
					next_st.mode = DPS_DORMANT;
					next_st.alert_ok = 1'b0;
				end else if (hit_s2j) begin
					// tap enters reset on the probe's trailing highs
					next_st.mode = DPS_JTAG;
					next_st.armed = 1'b0;
				end else if (line.strobe && cond_now) begin
					next_st.armed = 1'b1;
				end
			end
			DPS_DORMANT: begin
				// nothing but the alert and then a code is heard
				next_st.armed = 1'b0;
				if (!st.alert_ok) begin
					next_st.alert_ok = i_alert_seen;
				end else if (i_act_jtag) begin
					// tap resumes in the state it was left in
					next_st.mode = DPS_JTAG;
					next_st.alert_ok = 1'b0;
				end else if (i_act_swd) begin
					next_st.mode = DPS_SWD;
					next_st.alert_ok = 1'b0;
					next_st.swd_reset_req = 1'b1;
				end
			end
		endcase
	end

	// state register; powerup lands in the build's reset mode
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '{RST_MODE, 1'b0, 1'b0, `DPS_HIST_RST, 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign o_jtag_sel = (st.mode == DPS_JTAG);
	assign o_swd_sel = (st.mode == DPS_SWD);
	assign o_dormant = (st.mode == DPS_DORMANT);
	assign o_swd_reset_req = st.swd_reset_req;
	assign o_armed = st.armed;

	// checks --------------------------------------------------------

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	logic run_seen; // low in the first cycle after reset, high from the second on

	// marks the first cycle out of reset
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			run_seen <= 1'b0;
		end else begin
			run_seen <= 1'b1;
		end
	end

	// wake-up steps while dormant
	sequence s_alert;
		st.mode == DPS_DORMANT && !st.alert_ok && i_alert_seen;
	endsequence

	sequence s_act_jtag;
		st.mode == DPS_DORMANT && st.alert_ok && i_act_jtag;
	endsequence

	sequence s_act_swd;
		st.mode == DPS_DORMANT && st.alert_ok && !i_act_jtag && i_act_swd;
	endsequence

	a_powerup_mode: assert property (!run_seen |-> st.mode == RST_MODE)
		else $error("wrong protocol selected after reset");

	a_j2s_cause: assert property (
		($past(st.mode) == DPS_JTAG && st.mode == DPS_SWD) |->
		$past(line.strobe && st.armed && st.cond_hist[0] &&
		line.window == `DPS_J2S_PAT))
		else $error("switch to swd without a valid pattern");

	a_s2j_cause: assert property (
		($past(st.mode) == DPS_SWD && st.mode == DPS_JTAG) |->
		$past(line.strobe && st.armed && st.cond_hist[0] &&
		line.window == `DPS_S2J_PAT))
		else $error("switch to jtag without a valid pattern");

	a_swd_entry_reset: assert property (
		(st.mode != DPS_SWD && next_st.mode == DPS_SWD) |=>
		o_swd_reset_req && o_swd_sel)
		else $error("swd selected without line reset request");

	a_rearm_wait: assert property (
		(!st.armed && !(line.strobe && cond_now)) |=> !st.armed)
		else $error("detector re-armed without reset condition");

	a_dormant_entry: assert property (
		(st.mode != DPS_DORMANT && i_enter_dormant) |=> o_dormant)
		else $error("dormant entry request not taken");

	a_dormant_quiet: assert property (
		(st.mode == DPS_DORMANT && !st.alert_ok && !i_alert_seen) |=>
		o_dormant && !st.alert_ok)
		else $error("dormant state left without wake-up alert");

	a_wake_jtag: assert property (
		s_alert ##[1:8] s_act_jtag |=> o_jtag_sel && !o_swd_reset_req)
		else $error("jtag activation did not select jtag");

	a_wake_swd: assert property (
		s_alert ##[1:8] s_act_swd |=> o_swd_sel && o_swd_reset_req)
		else $error("swd activation did not reach line reset");

endmodule // dps_select

// ===== verif/debug_protocol_select_bench.sv
// testbench of the protocol select watcher
// assumes dps_probe drives the pins, bench drives the side inputs
`timescale 1ns/1ps

module debug_protocol_select_bench;
	import dps_pkg::*;
	logic i_sys_clk, i_rst, tlr, lrst;
	logic ent, alr, actj, acts; // enter, alert, act jtag, act swd
	wire dclk, ddat;
	logic jsel, ssel, dorm, req, armed;
	logic jsel2, ssel2, dorm2, req2, armed2; // two-wire-only flavour
	int error_cnt = 0, checked = 0, req_cnt = 0;

	dps_probe probe (.o_debug_clock_pin(dclk), .o_debug_mode_data_pin(ddat));
	dps_select uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_debug_clock_pin(dclk), .i_debug_mode_data_pin(ddat),
		.i_tap_in_tlr(tlr), .i_swd_line_reset(lrst),
		.i_enter_dormant(ent), .i_alert_seen(alr),
		.i_act_jtag(actj), .i_act_swd(acts), .o_jtag_sel(jsel),
		.o_swd_sel(ssel), .o_dormant(dorm), .o_swd_reset_req(req),
		.o_armed(armed));
	// two-wire-only flavour: powerup and wake-up from dormant
	dps_select #(.SWD_ONLY(1'b1)) uut_only (.i_sys_clk(i_sys_clk),
		.i_rst(i_rst), .i_debug_clock_pin(dclk),
		.i_debug_mode_data_pin(ddat), .i_tap_in_tlr(tlr),
		.i_swd_line_reset(lrst), .i_enter_dormant(ent),
		.i_alert_seen(alr), .i_act_jtag(actj), .i_act_swd(acts),
		.o_jtag_sel(jsel2), .o_swd_sel(ssel2), .o_dormant(dorm2),
		.o_swd_reset_req(req2), .o_armed(armed2));

	// system clock, 20 ns
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	// count line-reset request pulses
	always @(posedge i_sys_clk) begin
		if (req === 1'b1) req_cnt <= req_cnt + 1;
	end

	// wait eight cycles, then compare the value taken at the call
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		repeat (8) @(posedge i_sys_clk);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle pulse on the dormant group inputs
	task automatic pulse(input logic [3:0] k);
		@(posedge i_sys_clk) {ent, alr, actj, acts} <= k;
		@(posedge i_sys_clk) {ent, alr, actj, acts} <= 4'h0;
		repeat (2) @(posedge i_sys_clk);
	endtask

	// powerup state and first arming
	task automatic t_reset();
		chk({jsel, ssel, dorm, armed}, 4'b1000);
		chk({jsel2, ssel2, dorm2, req2, armed2}, 5'b00100);
		probe.send_high(50);
		chk({jsel, ssel, dorm, armed}, 4'b1001);
		$display("test reset done");
	endtask

	// pattern refused while tap is away from reset
	task automatic t_jtag_refuse();
		@(posedge i_sys_clk) tlr <= 1'b0;
		probe.send_msb(16'h79e7);
		chk({jsel, ssel, dorm}, 3'b100);
		@(posedge i_sys_clk) tlr <= 1'b1;
		$display("test jtag refuse done");
	endtask

	// jtag to two-wire switch and rearm on line reset
	task automatic t_to_swd();
		int r0;
		r0 = req_cnt;
		probe.send_high(50);
		probe.send_msb(16'h79e7);
		chk({jsel, ssel, dorm, armed}, 4'b0100);
		chk(req_cnt - r0, 1);
		@(posedge i_sys_clk) lrst <= 1'b1;
		probe.send_high(50);
		chk(armed, 1'b1);
		$display("test to swd done");
	endtask

	// patterns refused in two-wire mode
	task automatic t_swd_refuse();
		probe.send_msb(16'h79e7);
		chk({jsel, ssel, dorm}, 3'b010);
		@(posedge i_sys_clk) lrst <= 1'b0;
		// flush the window: the tail of 79e7 plus the head of 3ce7
		// forms the swd-to-jtag pattern from a line-reset start
		probe.send_high(16);
		probe.send_msb(16'h3ce7);
		chk({jsel, ssel, dorm}, 3'b010);
		@(posedge i_sys_clk) lrst <= 1'b1;
		$display("test swd refuse done");
	endtask

	// two-wire to jtag switch, rearm on tap reset
	task automatic t_to_jtag();
		probe.send_high(50);
		probe.send_msb(16'h3ce7);
		chk({jsel, ssel, dorm, armed}, 4'b1000);
		probe.send_high(5);
		chk(armed, 1'b1);
		$display("test to jtag done");
	endtask

	// dormant entry from both modes, alert and activation
	task automatic t_dormant();
		int r0;
		pulse(4'b1000);
		chk({jsel, ssel, dorm}, 3'b001);
		probe.send_high(50);
		probe.send_msb(16'h79e7);
		pulse(4'b0001);
		chk({jsel, ssel, dorm}, 3'b001);
		r0 = req_cnt;
		pulse(4'b0100);
		pulse(4'b0001);
		chk({jsel, ssel, dorm}, 3'b010);
		chk(req_cnt - r0, 1);
		chk({jsel2, ssel2, dorm2, req2, armed2}, 5'b01000);
		pulse(4'b1000);
		chk({jsel, ssel, dorm}, 3'b001);
		pulse(4'b0100);
		pulse(4'b0010);
		#3 probe.send_bit(1'b0);
		chk({jsel, ssel, dorm}, 3'b100);
		chk({jsel2, ssel2, dorm2}, 3'b100);
		$display("test dormant done");
	endtask

	// counts, verdict and end of run
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		i_rst = 1'b1;
		tlr = 1'b1;
		lrst = 1'b0;
		{ent, alr, actj, acts} = 4'h0;
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		t_reset();
		t_jtag_refuse();
		t_to_swd();
		t_swd_refuse();
		t_to_jtag();
		t_dormant();
		give_verdict();
	end

	// watchdog: tests need well under 200 us
	initial begin
		#1000000;
		error_cnt++;
		give_verdict();
	end
endmodule // debug_protocol_select_bench

// ===== verif/dps_probe.sv
// partner model: debug probe driving debug clock and mode/data pins
// assumes the watcher samples the line on debug clock rising edges
`timescale 1ns/1ps

module dps_probe (
	output logic o_debug_clock_pin,
	output logic o_debug_mode_data_pin
);
	// clock parked low between frames, line idles high
	initial begin
		o_debug_clock_pin = 1'b0;
		o_debug_mode_data_pin = 1'b1;
	end

	// one bit: data set while clock low, taken on the rise, 160 ns
	task automatic send_bit(input logic b);
		o_debug_mode_data_pin = b;
		#80 o_debug_clock_pin = 1'b1;
		#80 o_debug_clock_pin = 1'b0;
	endtask

	// run of clocks with the line high; offset keeps off sys edges
	task automatic send_high(input int n);
		#3;
		for (int i = 0; i < n; i++) send_bit(1'b1);
	endtask

	// switch pattern sent most significant bit first
	task automatic send_msb(input logic [15:0] v);
		#3;
		for (int i = 15; i >= 0; i--) send_bit(v[i]);
	endtask
endmodule // dps_probe
